// ==== core/ccio_regs.vh ====
// register map, field positions and reset values of the compare/capture block
`ifndef CCIO_REGS_VH
`define CCIO_REGS_VH

`define NUM_CHANNELS    5
`define COUNTER_WIDTH   16
`define NO_TOGGLE_CHAN  2
`define PHASE_CHAN      2

`define ADDR_IOC_BASE   4'h0
`define ADDR_STS_BASE   4'h8
`define UNMAPPED_READ   8'h00

`define IOC_RESET       8'h88
`define IOC_FIXED_ONES  8'h88
`define STS_RESET       8'hF8
`define STS_FIXED_ONES  8'hF8

`define FUNC_B_LSB      4
`define FUNC_A_LSB      0
`define FUNC_HI         2

`define FLAG_WRAP       2
`define FLAG_B          1
`define FLAG_A          0

`define OUT_NONE        2'h0
`define OUT_ZERO        2'h1
`define OUT_ONE         2'h2
`define OUT_TOGGLE      2'h3
`define CAP_RISE        2'h0
`define CAP_FALL        2'h1

`define COUNTER_MAX     16'hFFFF
`define COUNTER_MIN     16'h0000

`endif

// ==== core/gr_unit.v ====
// compare output and input capture logic for one general register
`timescale 1ns/100ps
`default_nettype none
`include "ccio_regs.vh"

module gr_unit #(
  parameter CNT_W     = `COUNTER_WIDTH,
  parameter TOGGLE_OK = 1
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             standby_in,
  input  wire [2:0]       func_in,
  input  wire [CNT_W-1:0] counter_in,
  input  wire [CNT_W-1:0] gr_in,
  input  wire             pin_in,
  output reg              pin_out,
  output wire             pin_oe_out,
  output wire             event_out,
  output wire             capture_out
);

  wire       capture_mode = func_in[`FUNC_HI];
  wire [1:0] code         = func_in[1:0];

  reg  sync1_q;
  reg  sync2_q;
  reg  last_q;
  reg  eq_q;

  wire rise  = sync2_q & ~last_q;
  wire fall  = ~sync2_q & last_q;
  wire eq    = (counter_in == gr_in);
  wire match = ~capture_mode & eq & ~eq_q;

  reg  edge_hit;

  // both-edge codes 10 and 11 behave the same
  always @* begin
    case (code)
      `CAP_RISE: edge_hit = rise;
      `CAP_FALL: edge_hit = fall;
      default:   edge_hit = rise | fall;
    endcase
  end

  assign capture_out = capture_mode & edge_hit;
  assign event_out   = match | capture_out;
  // pin is only driven while a compare output action is chosen
  assign pin_oe_out  = ~capture_mode & (code != `OUT_NONE);

  // the first stage feeds only the second; edges come from stage two
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
      eq_q    <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
      // match fires once on entry, not every cycle the count stalls
      eq_q    <= eq;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= 1'b0;
    end else if (standby_in) begin
      pin_out <= 1'b0;
    end else if (match) begin
      case (code)
        `OUT_ZERO:   pin_out <= 1'b0;
        `OUT_ONE:    pin_out <= 1'b1;
        `OUT_TOGGLE: pin_out <= TOGGLE_OK ? ~pin_out : 1'b1;
        default:     pin_out <= pin_out;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== core/compare_capture_io_status.v ====
// per-channel i/o control and status registers of the five-channel timer
`timescale 1ns/100ps
`default_nettype none
`include "ccio_regs.vh"

module compare_capture_io_status #(
  parameter NUM_CH = `NUM_CHANNELS,
  parameter CNT_W  = `COUNTER_WIDTH
) (
  input  wire                    ref_clk_in,
  input  wire                    rstn_in,
  input  wire                    standby_in,
  input  wire [3:0]              cpu_addr_in,
  input  wire                    cpu_rd_in,
  input  wire                    cpu_wr_in,
  input  wire [7:0]              cpu_wdata_in,
  output reg  [7:0]              cpu_rdata_out,
  input  wire                    phase_count_select_in,
  input  wire [NUM_CH*CNT_W-1:0] channel_counter_in,
  input  wire [NUM_CH*CNT_W-1:0] general_reg_a_in,
  input  wire [NUM_CH*CNT_W-1:0] general_reg_b_in,
  input  wire [NUM_CH*3-1:0]     interrupt_enable_in,
  input  wire [NUM_CH-1:0]       compare_capture_pin_a_in,
  output wire [NUM_CH-1:0]       compare_capture_pin_a_out,
  output wire [NUM_CH-1:0]       compare_capture_pin_a_oe_out,
  input  wire [NUM_CH-1:0]       compare_capture_pin_b_in,
  output wire [NUM_CH-1:0]       compare_capture_pin_b_out,
  output wire [NUM_CH-1:0]       compare_capture_pin_b_oe_out,
  output reg  [NUM_CH-1:0]       capture_a_out,
  output reg  [NUM_CH-1:0]       capture_b_out,
  output reg  [NUM_CH-1:0]       irq_wrap_out,
  output reg  [NUM_CH-1:0]       irq_b_out,
  output reg  [NUM_CH-1:0]       irq_a_out
);

  // reset release through two flops
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n = rst_sync_q;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // register storage, indexed by channel
  reg [7:0] io_ctrl_q [0:NUM_CH-1];
  reg [2:0] flag_q    [0:NUM_CH-1];
  reg [2:0] armed_q   [0:NUM_CH-1];

  wire [NUM_CH-1:0] ioc_sel;
  wire [NUM_CH-1:0] sts_sel;
  wire [NUM_CH-1:0] ev_a;
  wire [NUM_CH-1:0] ev_b;
  wire [NUM_CH-1:0] cap_a;
  wire [NUM_CH-1:0] cap_b;
  wire [NUM_CH-1:0] wrap_ev;

  reg [CNT_W-1:0] cnt_prev_q [0:NUM_CH-1];
  reg [NUM_CH-1:0] prev_ok_q;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
      // full-width sums, cut to the 4-bit address where they are compared
      localparam [31:0] IOC_ADDR = `ADDR_IOC_BASE + ch;
      localparam [31:0] STS_ADDR = `ADDR_STS_BASE + ch;
      localparam       NO_TGL   = (ch == `NO_TOGGLE_CHAN);
      localparam       PHASE_OK = (ch == `PHASE_CHAN);

      wire [CNT_W-1:0] cnt = channel_counter_in[ch*CNT_W +: CNT_W];
      wire [CNT_W-1:0] general_reg_a = general_reg_a_in[ch*CNT_W +: CNT_W];
      wire [CNT_W-1:0] general_reg_b = general_reg_b_in[ch*CNT_W +: CNT_W];
      wire [2:0]       ien = interrupt_enable_in[ch*3 +: 3];

      wire [2:0] func_b = io_ctrl_q[ch][`FUNC_B_LSB +: 3];
      wire [2:0] func_a = io_ctrl_q[ch][`FUNC_A_LSB +: 3];

      assign ioc_sel[ch] = (cpu_addr_in == IOC_ADDR[3:0]);
      assign sts_sel[ch] = (cpu_addr_in == STS_ADDR[3:0]);

      // down counting is legal only in channel 2 with phase counting on
      wire down_ok = PHASE_OK & phase_count_select_in;
      wire ovf  = (cnt_prev_q[ch] == `COUNTER_MAX) &
                  (cnt == `COUNTER_MIN);
      wire udf  = (cnt_prev_q[ch] == `COUNTER_MIN) &
                  (cnt == `COUNTER_MAX) & down_ok;
      // a software load that jumps across the wrap also counts as one
      assign wrap_ev[ch] = prev_ok_q[ch] & (ovf | udf);

      gr_unit #(
        .CNT_W     (CNT_W),
        .TOGGLE_OK (NO_TGL ? 0 : 1)
      ) u_gr_a (
        .clk_in      (ref_clk_in),
        .rst_n_in    (rst_n),
        .standby_in  (standby_in),
        .func_in     (func_a),
        .counter_in  (cnt),
        .gr_in       (general_reg_a),
        .pin_in      (compare_capture_pin_a_in[ch]),
        .pin_out     (compare_capture_pin_a_out[ch]),
        .pin_oe_out  (compare_capture_pin_a_oe_out[ch]),
        .event_out   (ev_a[ch]),
        .capture_out (cap_a[ch])
      );

      gr_unit #(
        .CNT_W     (CNT_W),
        .TOGGLE_OK (NO_TGL ? 0 : 1)
      ) u_gr_b (
        .clk_in      (ref_clk_in),
        .rst_n_in    (rst_n),
        .standby_in  (standby_in),
        .func_in     (func_b),
        .counter_in  (cnt),
        .gr_in       (general_reg_b),
        .pin_in      (compare_capture_pin_b_in[ch]),
        .pin_out     (compare_capture_pin_b_out[ch]),
        .pin_oe_out  (compare_capture_pin_b_oe_out[ch]),
        .event_out   (ev_b[ch]),
        .capture_out (cap_b[ch])
      );

      wire [2:0] set_ev = {wrap_ev[ch], ev_b[ch], ev_a[ch]};
      wire       st_wr  = cpu_wr_in & sts_sel[ch];
      wire       st_rd  = cpu_rd_in & sts_sel[ch];
      // a flag only clears when it was seen at one before the write
      wire [2:0] clr    = {3{st_wr}} & ~cpu_wdata_in[2:0] &
                          armed_q[ch];

      // i/o control: bits 7 and 3 are fixed, the rest are writable
      always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          io_ctrl_q[ch] <= `IOC_RESET;
        end else if (standby_in) begin
          io_ctrl_q[ch] <= `IOC_RESET;
        end else if (cpu_wr_in & ioc_sel[ch]) begin
          io_ctrl_q[ch] <= cpu_wdata_in | `IOC_FIXED_ONES;
        end
      end

      // writes of one leave a flag alone; set beats clear
      always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          flag_q[ch] <= 3'h0;
        end else if (standby_in) begin
          flag_q[ch] <= 3'h0;
        end else begin
          flag_q[ch] <= (flag_q[ch] & ~clr) | set_ev;
        end
      end

      // arming follows a read that saw the flag at one; a write to this status register ends it
      always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          armed_q[ch] <= 3'h0;
        end else if (standby_in | st_wr) begin
          armed_q[ch] <= 3'h0;
        end else if (st_rd) begin
          armed_q[ch] <= armed_q[ch] | flag_q[ch];
        end
      end

      always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          cnt_prev_q[ch] <= `COUNTER_MIN;
          prev_ok_q[ch]  <= 1'b0;
        end else begin
          cnt_prev_q[ch] <= cnt;
          prev_ok_q[ch]  <= 1'b1;
        end
      end

      // request stays up while flag and its enable are both set
      always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          irq_wrap_out[ch]  <= 1'b0;
          irq_b_out[ch]     <= 1'b0;
          irq_a_out[ch]     <= 1'b0;
          capture_a_out[ch] <= 1'b0;
          capture_b_out[ch] <= 1'b0;
        end else begin
          irq_wrap_out[ch]  <= flag_q[ch][`FLAG_WRAP] &
                               ien[`FLAG_WRAP];
          irq_b_out[ch]     <= flag_q[ch][`FLAG_B] & ien[`FLAG_B];
          irq_a_out[ch]     <= flag_q[ch][`FLAG_A] & ien[`FLAG_A];
          // load strobe for the general register, one cycle
          capture_a_out[ch] <= cap_a[ch];
          capture_b_out[ch] <= cap_b[ch];
        end
      end
    end
  endgenerate

  // read path: one mux over all channel registers
  reg [7:0] rd_mux;
  integer   i;

  always @* begin
    rd_mux = `UNMAPPED_READ;
    for (i = 0; i < NUM_CH; i = i + 1) begin
      if (ioc_sel[i]) begin
        rd_mux = io_ctrl_q[i] | `IOC_FIXED_ONES;
      end
      if (sts_sel[i]) begin
        rd_mux = {5'h00, flag_q[i]} | `STS_FIXED_ONES;
      end
    end
  end

  // read data held until the next read
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata_out <= 8'h00;
    end else if (cpu_rd_in) begin
      cpu_rdata_out <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ==== verif/ccio_checker.sv ====
// port assertions of the compare/capture block
`timescale 1ns/100ps
`default_nettype none
module ccio_checker #(
  parameter NUM_CH = 5,
  parameter CNT_W  = 16
) (
  input wire logic                    ref_clk_in,
  input wire logic                    rstn_in,
  input wire logic                    standby_in,
  input wire logic [3:0]              cpu_addr_in,
  input wire logic                    cpu_rd_in,
  input wire logic [7:0]              cpu_rdata_out,
  input wire logic [NUM_CH*CNT_W-1:0] channel_counter_in,
  input wire logic [NUM_CH*CNT_W-1:0] general_reg_a_in,
  input wire logic [NUM_CH*CNT_W-1:0] general_reg_b_in,
  input wire logic [NUM_CH*3-1:0]     interrupt_enable_in,
  input wire logic [NUM_CH-1:0]       compare_capture_pin_a_oe_out,
  input wire logic [NUM_CH-1:0]       compare_capture_pin_b_oe_out,
  input wire logic [NUM_CH-1:0]       capture_b_out,
  input wire logic [NUM_CH-1:0]       irq_wrap_out,
  input wire logic [NUM_CH-1:0]       irq_b_out,
  input wire logic [NUM_CH-1:0]       irq_a_out
);
  // wrap and match checks wait until the synchronised reset is well over
  logic [2:0] up_q;
  wire        ok = up_q == 3'h5 && !standby_in;
  wire        rd_ioc = cpu_rd_in && cpu_addr_in < 4'h5;
  wire        rd_sts = cpu_rd_in && cpu_addr_in > 4'h7 && cpu_addr_in < 4'hD;
  wire [7:0]  d = cpu_rdata_out;
  wire [15:0] c0 = channel_counter_in[15:0];
  wire        ea = ok && compare_capture_pin_a_oe_out[0];
  wire        eb = ok && compare_capture_pin_b_oe_out[0];
  always @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in) up_q <= 3'h0;
    else if (up_q != 3'h5) up_q <= up_q + 3'h1;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence wrap0;
    $past(c0) == 16'hFFFF && c0 == 16'h0000;
  endsequence
  sequence hit_a;
    $rose(c0 == general_reg_a_in[15:0]);
  endsequence
  sequence hit_b;
    $rose(c0 == general_reg_b_in[15:0]);
  endsequence
  a_ioc_ones: assert property (rd_ioc |=> d[7] && d[3])
    else $error("control fixed bits not one");
  a_sts_ones: assert property (rd_sts |=> d[7:3] == 5'h1F)
    else $error("status fixed bits not one");
  a_rd_none: assert property (cpu_rd_in && !rd_ioc && !rd_sts |=> d == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!cpu_rd_in |=> $stable(d))
    else $error("read data moved without a read");
  a_wrap_irq: assert property (ok && interrupt_enable_in[2] ##0 wrap0
    |-> ##2 irq_wrap_out[0]) else $error("wrap gave no request");
  a_match_a: assert property (ea && interrupt_enable_in[0] ##0 hit_a
    |-> ##2 irq_a_out[0]) else $error("match a gave no request");
  a_match_b: assert property (eb && interrupt_enable_in[1] ##0 hit_b
    |-> ##2 irq_b_out[0]) else $error("match b gave no request");
  a_cap_once: assert property (capture_b_out[1] |=> !capture_b_out[1])
    else $error("capture strobe longer than a cycle");
  a_cap_irq: assert property (capture_b_out[1] && interrupt_enable_in[4]
    |=> irq_b_out[1]) else $error("capture gave no request");
endmodule
bind compare_capture_io_status ccio_checker #(
  .NUM_CH(NUM_CH), .CNT_W(CNT_W)) i_chk (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .standby_in(standby_in),
  .cpu_addr_in(cpu_addr_in), .cpu_rd_in(cpu_rd_in),
  .cpu_rdata_out(cpu_rdata_out), .channel_counter_in(channel_counter_in),
  .general_reg_a_in(general_reg_a_in), .general_reg_b_in(general_reg_b_in),
  .interrupt_enable_in(interrupt_enable_in),
  .compare_capture_pin_a_oe_out(compare_capture_pin_a_oe_out),
  .compare_capture_pin_b_oe_out(compare_capture_pin_b_oe_out),
  .capture_b_out(capture_b_out), .irq_wrap_out(irq_wrap_out),
  .irq_b_out(irq_b_out), .irq_a_out(irq_a_out));
`default_nettype wire

// ==== verif/pin_side.sv ====
// far-side model of the compare/capture pins
`timescale 1ns/100ps
`default_nettype none
module pin_side (
  input  wire logic [4:0] a_lvl_in,
  input  wire logic [4:0] b_lvl_in,
  input  wire logic [4:0] a_out_in,
  input  wire logic [4:0] a_oe_in,
  input  wire logic [4:0] b_out_in,
  input  wire logic [4:0] b_oe_in,
  output logic      [4:0] a_pin_out,
  output logic      [4:0] b_pin_out
);
  // a driven pin shows the device level, otherwise the far side wins
  assign a_pin_out = (a_oe_in & a_out_in) | (~a_oe_in & a_lvl_in);
  assign b_pin_out = (b_oe_in & b_out_in) | (~b_oe_in & b_lvl_in);
endmodule
`default_nettype wire

// ==== verif/compare_capture_io_status_tb.sv ====
// self-checking bench of the compare/capture block
`timescale 1ns/100ps
`default_nettype none
module compare_capture_io_status_tb;
  logic        clk = 1'b0, rstn = 1'b0, sb = 1'b0, ph = 1'b0;
  logic        cpu_rd = 1'b0, cpu_wr = 1'b0;
  logic [14:0] ien = 15'h7FFF;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wd = 8'h00, rdata, rv;
  logic [79:0] cnt = 80'h0, general_reg_a = {5{16'h0005}}, general_reg_b = {5{16'h0005}};
  logic [4:0]  pa = 5'h00, pb = 5'h00, pai, pbi, ao, aoe, bo, boe;
  logic [4:0]  ca, cb, iw, ib, ia;
  int          n_fail = 0, compares = 0, cyc = 0, ncap = 0, nca = 0;
  always #10 clk = ~clk;
  compare_capture_io_status i_dut (
    .ref_clk_in(clk), .rstn_in(rstn), .standby_in(sb),
    .cpu_addr_in(addr), .cpu_rd_in(cpu_rd), .cpu_wr_in(cpu_wr),
    .cpu_wdata_in(wd), .cpu_rdata_out(rdata),
    .phase_count_select_in(ph), .channel_counter_in(cnt),
    .general_reg_a_in(general_reg_a), .general_reg_b_in(general_reg_b),
    .interrupt_enable_in(ien),
    .compare_capture_pin_a_in(pai), .compare_capture_pin_a_out(ao),
    .compare_capture_pin_a_oe_out(aoe), .compare_capture_pin_b_in(pbi),
    .compare_capture_pin_b_out(bo), .compare_capture_pin_b_oe_out(boe),
    .capture_a_out(ca), .capture_b_out(cb), .irq_wrap_out(iw),
    .irq_b_out(ib), .irq_a_out(ia));
  pin_side i_pins (.a_lvl_in(pa), .b_lvl_in(pb), .a_out_in(ao),
    .a_oe_in(aoe), .b_out_in(bo), .b_oe_in(boe), .a_pin_out(pai),
    .b_pin_out(pbi));
  always @(posedge clk) begin
    if (cb[1] === 1'b1) ncap = ncap + 1;
    if (ca[1] === 1'b1) nca = nca + 1;
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  task results;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input [3:0] a);
    @(posedge clk) {addr, cpu_rd} <= {a, 1'b1};
    @(posedge clk) cpu_rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task wr(input [3:0] a, input [7:0] v);
    @(posedge clk) {addr, wd, cpu_wr} <= {a, v, 1'b1};
    @(posedge clk) cpu_wr <= 1'b0;
  endtask
  // counter stays put long enough for the block to sample it at least three times
  task cv(input int ch, input [15:0] v);
    @(posedge clk) cnt[ch*16+:16] <= v;
    repeat (3) @(posedge clk);
  endtask
  task t_reset;
    chk(ao, 5'h00);
    chk(aoe | boe, 5'h00);
    for (int i = 0; i < 5; i++) begin
      rd(i[3:0]);
      chk(rv, 8'h88);
      rd(i[3:0] + 4'h8);
      chk(rv, 8'hF8);
    end
    rd(4'h5);
    chk(rv, 8'h00);
    wr(4'h2, 8'h12);
    rd(4'h2);
    chk(rv, 8'h9A);
    wr(4'h2, 8'h00);
    rd(4'h2);
    chk(rv, 8'h88);
  endtask
  task t_cmp;
    logic [1:0] c [6] = '{2'h2, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3};
    logic       e [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int         ch;
    for (int i = 0; i < 6; i++) begin
      ch = i < 4 ? 0 : 2;
      wr(ch[3:0], {2'h0, c[i], 2'h0, c[i]});
      cv(ch, 16'h0005);
      cv(ch, 16'h0000);
      chk(ao[ch], e[i]);
      chk(bo[ch], e[i]);
    end
  endtask
  task t_flag;
    chk(ia[0], 1'b1);
    @(posedge clk) ien[0] <= 1'b0;
    repeat (2) @(posedge clk);
    chk(ia[0], 1'b0);
    ien[0] <= 1'b1;
    rd(4'h8);
    chk(rv, 8'hFB);
    wr(4'h8, 8'hFF);
    wr(4'h8, 8'h00);
    rd(4'h8);
    chk(rv, 8'hFB);
    wr(4'h8, 8'hFE);
    rd(4'h8);
    chk(rv, 8'hFA);
  endtask
  task t_cap;
    int e [4] = '{1, 1, 2, 2};
    int n, m;
    for (int i = 0; i < 4; i++) begin
      wr(4'h1, {2'h1, i[1:0], 2'h1, i[1:0]});
      // enables settle after the write edge, look just past it
      #1 chk(boe[1], 1'b0);
      chk(aoe[1], 1'b0);
      rd(4'h9);
      wr(4'h9, 8'h00);
      n = ncap;
      m = nca;
      @(posedge clk) {pa[1], pb[1]} <= 2'h3;
      repeat (8) @(posedge clk);
      {pa[1], pb[1]} <= 2'h0;
      repeat (8) @(posedge clk);
      chk(ncap - n, e[i]);
      chk(nca - m, e[i]);
      rd(4'h9);
      chk(rv, 8'hFB);
    end
  endtask
  task t_wrap;
    cv(0, 16'hFFFF);
    rd(4'h8);
    chk(rv[2], 1'b0);
    cv(0, 16'h0000);
    rd(4'h8);
    chk(rv[2], 1'b1);
    cv(2, 16'hFFFF);
    rd(4'hA);
    chk(rv[2], 1'b0);
    cv(2, 16'h1234);
    cv(2, 16'h0000);
    ph <= 1'b1;
    cv(2, 16'hFFFF);
    rd(4'hA);
    chk(rv[2], 1'b1);
  endtask
  task t_sby;
    wr(4'h0, 8'h12);
    @(posedge clk) sb <= 1'b1;
    repeat (2) @(posedge clk);
    sb <= 1'b0;
    rd(4'h0);
    chk(rv, 8'h88);
    rd(4'h8);
    chk(rv, 8'hF8);
    chk(ao, 5'h00);
    chk(bo, 5'h00);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_cmp;
    t_flag;
    t_cap;
    t_wrap;
    t_sby;
    results;
  end
endmodule
`default_nettype wire
